/* File: core/scc_port_pkg.sv */
// constants for the dual serial controller host port
package scc_port_pkg;
	localparam int DATA_W = 8;
	localparam int N_CH = 2;
	localparam logic [7:0] VECTOR_RST = 8'h00;
	localparam logic [7:0] IE_RST = 8'h00;
	localparam logic SYNC_RST = 1'b1;
	// command codes written with data/command select low
	localparam logic [2:0] CMD_SEL_BIT = 3'h0;
	localparam logic [2:0] CMD_DTR_BIT = 3'h1;
	localparam logic [2:0] CMD_AUTO_BIT = 3'h2;
	localparam logic [2:0] CMD_CTS_IE_BIT = 3'h3;
	localparam logic [2:0] CMD_DCD_IE_BIT = 3'h4;
	localparam logic [2:0] CMD_DMA_BIT = 3'h5;
	localparam logic [2:0] CMD_TX_REQ_BIT = 3'h6;
	localparam logic [2:0] CMD_RST_IRQ_BIT = 3'h7;
	// status bit positions on a command read
	localparam logic [2:0] STAT_CTS_BIT = 3'h0;
	localparam logic [2:0] STAT_DCD_BIT = 3'h1;
	localparam logic [2:0] STAT_PEND_BIT = 3'h2;
	localparam logic [2:0] STAT_AUTO_BIT = 3'h3;
endpackage

/* File: core/dual_serial_ctrl_host_port.sv */
// host port: bus access, modem pins and interrupt daisy chain
// Operation
// R1 - channel select steers access to one channel
// R2 - accesses taken only with chip enable low
// R3 - data/command select: high data, low command
// R4 - drive data lines only during own reads
// R5 - auto-enable: low clear-to-send enables transmitter
// R6 - otherwise clear-to-send is readable input
// R7 - clear-to-send edges raise interrupt
// R8 - carrier detect auto-enables receiver, else input
// R9 - carrier detect edges raise interrupt
// R10 - terminal-ready output follows programmed bit
// R11 - terminal-ready also general output or request
// R12 - upstream drives enable-in high when idle
// R13 - enable-out high only when idle and enabled
// R14 - enable-out low blocks lower chain devices
// R15 - open-drain interrupt low while pending; code releases it from acknowledge until no channel is pending
// R16 - acknowledge with read and enable-in gives vector
// R17 - acknowledge sampled on clock rising edge
// R18 - read strobe enables drivers while selected
// R19 - data lines released when not selected
`timescale 1ns/1ps
module dual_serial_ctrl_host_port
	import scc_port_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_chip_en_n,
	input wire logic i_chan_sel,
	input wire logic i_data_cmd,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [DATA_W-1:0] i_host_data_bus,
	output logic [DATA_W-1:0] o_host_data_bus,
	output logic o_host_data_bus_oe_n,
	input wire logic i_irq_ack_n,
	input wire logic i_prio_chain_in,
	output logic o_prio_chain_out,
	output logic o_irq_n_oe_n,
	input wire logic i_clear_to_send_n_ch0,
	input wire logic i_clear_to_send_n_ch1,
	input wire logic i_carrier_detect_n_ch0,
	input wire logic i_carrier_detect_n_ch1,
	input wire logic [N_CH-1:0] i_dma_req,
	input wire logic [DATA_W-1:0] i_rx_data_ch0,
	input wire logic [DATA_W-1:0] i_rx_data_ch1,
	output logic [N_CH-1:0] o_tx_enable,
	output logic [N_CH-1:0] o_rx_enable,
	output logic [N_CH-1:0] o_wr_data_stb,
	output logic [DATA_W-1:0] o_wr_data,
	output logic [N_CH-1:0] o_rd_data_stb,
	output logic o_term_ready_req_n_ch0,
	output logic o_term_ready_req_n_ch1
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int NS = 9;
	logic [NS-1:0] raw_in, meta_ff, sync_ff;
	assign raw_in = {i_chip_en_n, i_chan_sel, i_data_cmd, i_rd_n, i_wr_n, i_irq_ack_n,
		i_prio_chain_in, i_clear_to_send_n_ch1, i_clear_to_send_n_ch0};
	logic [N_CH-1:0] dcd_meta_ff, dcd_ff;
	logic [DATA_W-1:0] data_meta_ff, data_ff;
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			meta_ff <= '1;
			sync_ff <= '1;
			dcd_meta_ff <= '1;
			dcd_ff <= '1;
			data_meta_ff <= '0;
			data_ff <= '0;
		end
		else
		begin
			meta_ff <= raw_in;
			sync_ff <= meta_ff;
			dcd_meta_ff <= {i_carrier_detect_n_ch1, i_carrier_detect_n_ch0};
			dcd_ff <= dcd_meta_ff;
			data_meta_ff <= i_host_data_bus;
			data_ff <= data_meta_ff;
		end
	end
	logic ce_n, ch_sel, dc_sel, rd_n, wr_n, ack_n, chain_in;
	logic [N_CH-1:0] cts_n;
	assign {ce_n, ch_sel, dc_sel, rd_n, wr_n, ack_n, chain_in, cts_n} = sync_ff; // R12 R17

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	logic wr_prev_ff, rd_prev_ff;
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			wr_prev_ff <= 1'b1;
			rd_prev_ff <= 1'b1;
		end
		else
		begin
			wr_prev_ff <= wr_n;
			rd_prev_ff <= rd_n;
		end
	end
	logic wr_go, rd_go, ack_rd;
	assign wr_go = !ce_n && !wr_n && wr_prev_ff && ack_n; // R2
	assign rd_go = !ce_n && !rd_n && rd_prev_ff && ack_n; // R2
	assign ack_rd = !ack_n && !rd_n && chain_in; // R16

	// ----------------------------------------
	// per-channel control, modem pins, events
	// ----------------------------------------
	logic [N_CH-1:0] dtr_ff, auto_ff, cts_ie_ff, dcd_ie_ff, dma_ff;
	logic [N_CH-1:0] cts_prev_ff, dcd_prev_ff, pend_ff, tx_en_ff, rx_en_ff, term_ff;
	logic [N_CH-1:0] wstb_ff, rstb_ff, cmd_hit, data_hit;
	genvar g;
	generate
		for (g = 0; g < N_CH; g++)
		begin : g_ch
			assign cmd_hit[g] = wr_go && !dc_sel && (ch_sel == 1'(g)); // R1 R3
			assign data_hit[g] = wr_go && dc_sel && (ch_sel == 1'(g)); // R1 R3
			always_ff @(posedge i_ref_clk)
			begin
				if (i_rst)
				begin
					dtr_ff[g] <= 1'b0;
					auto_ff[g] <= 1'b0;
					cts_ie_ff[g] <= 1'b0;
					dcd_ie_ff[g] <= 1'b0;
					dma_ff[g] <= 1'b0;
				end
				else if (cmd_hit[g] && data_ff[CMD_SEL_BIT])
				begin
					dtr_ff[g] <= data_ff[CMD_DTR_BIT];
					auto_ff[g] <= data_ff[CMD_AUTO_BIT];
					cts_ie_ff[g] <= data_ff[CMD_CTS_IE_BIT];
					dcd_ie_ff[g] <= data_ff[CMD_DCD_IE_BIT];
					dma_ff[g] <= data_ff[CMD_DMA_BIT];
				end
			end
			always_ff @(posedge i_ref_clk)
			begin
				if (i_rst)
				begin
					cts_prev_ff[g] <= 1'b1;
					dcd_prev_ff[g] <= 1'b1;
					pend_ff[g] <= 1'b0;
				end
				else
				begin
					cts_prev_ff[g] <= cts_n[g];
					dcd_prev_ff[g] <= dcd_ff[g];
					// set wins over clear
					if ((cts_ie_ff[g] && (cts_n[g] != cts_prev_ff[g])) // R7
						|| (dcd_ie_ff[g] && (dcd_ff[g] != dcd_prev_ff[g]))) // R9
						pend_ff[g] <= 1'b1;
					else if (cmd_hit[g] && data_ff[CMD_RST_IRQ_BIT])
						pend_ff[g] <= 1'b0;
				end
			end
			always_ff @(posedge i_ref_clk)
			begin
				if (i_rst)
				begin
					tx_en_ff[g] <= 1'b0;
					rx_en_ff[g] <= 1'b0;
					term_ff[g] <= 1'b1;
					wstb_ff[g] <= 1'b0;
					rstb_ff[g] <= 1'b0;
				end
				else
				begin
					tx_en_ff[g] <= auto_ff[g] ? !cts_n[g] : 1'b1; // R5 R6
					rx_en_ff[g] <= auto_ff[g] ? !dcd_ff[g] : 1'b1; // R8
					term_ff[g] <= dma_ff[g] ? !i_dma_req[g] : !dtr_ff[g]; // R10 R11
					wstb_ff[g] <= data_hit[g];
					rstb_ff[g] <= rd_go && dc_sel && (ch_sel == 1'(g)); // R1
				end
			end
		end
	endgenerate
	assign o_tx_enable = tx_en_ff;
	assign o_rx_enable = rx_en_ff;
	assign {o_term_ready_req_n_ch1, o_term_ready_req_n_ch0} = term_ff;
	assign o_wr_data_stb = wstb_ff;
	assign o_rd_data_stb = rstb_ff;

	// ----------------------------------------
	// write data, read data and bus drive
	// ----------------------------------------
	logic [DATA_W-1:0] wdata_ff, rdata_ff, vector_ff, nxt_rdata;
	logic oe_n_ff;
	always_comb
	begin
		logic [DATA_W-1:0] st;
		st = '0;
		st[STAT_CTS_BIT] = cts_n[ch_sel];
		st[STAT_DCD_BIT] = dcd_ff[ch_sel];
		st[STAT_PEND_BIT] = pend_ff[ch_sel];
		st[STAT_AUTO_BIT] = auto_ff[ch_sel];
		if (ack_rd)
			nxt_rdata = vector_ff; // R16
		else if (dc_sel)
			nxt_rdata = ch_sel ? i_rx_data_ch1 : i_rx_data_ch0;
		else
			nxt_rdata = st; // R6
	end
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			wdata_ff <= '0;
			vector_ff <= VECTOR_RST;
		end
		else
		begin
			if (|data_hit)
				wdata_ff <= data_ff;
			if (wr_go && !dc_sel && !data_ff[CMD_SEL_BIT] && data_ff[CMD_TX_REQ_BIT])
				vector_ff <= {data_ff[DATA_W-1:1], 1'b0};
		end
	end
	assign o_wr_data = wdata_ff;
	logic any_pend;
	assign any_pend = |pend_ff;
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			rdata_ff <= '0;
			oe_n_ff <= 1'b1;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
			oe_n_ff <= !(ack_rd || (!ce_n && !rd_n && ack_n)); // R4 R18 R19
		end
	end
	assign o_host_data_bus = rdata_ff;
	assign o_host_data_bus_oe_n = oe_n_ff;

	// ----------------------------------------
	// interrupt request and daisy chain
	// ----------------------------------------
	logic irq_oe_n_ff, chain_out_ff, in_service_ff;
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			in_service_ff <= 1'b0;
			irq_oe_n_ff <= 1'b1;
			chain_out_ff <= 1'b0;
		end
		else
		begin
			if (ack_rd && any_pend)
				in_service_ff <= 1'b1;
			else if (!any_pend)
				in_service_ff <= 1'b0;
			irq_oe_n_ff <= !(any_pend && !in_service_ff); // R15
			chain_out_ff <= chain_in && !any_pend && !in_service_ff; // R13 R14
		end
	end
	assign o_irq_n_oe_n = irq_oe_n_ff;
	assign o_prio_chain_out = chain_out_ff;

	a_chain_blocks: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(any_pend || !chain_in) |=> !o_prio_chain_out) // R13
		else $error("enable-out high while busy");
	a_irq_pending: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(!any_pend) |=> o_irq_n_oe_n) // R15
		else $error("interrupt driven without pending");
	a_bus_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(ce_n && !ack_rd) |=> o_host_data_bus_oe_n) // R19
		else $error("bus driven when unselected");
	a_read_drive: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(!ce_n && !rd_n && ack_n) |=> !o_host_data_bus_oe_n) // R18
		else $error("read not driven");
	a_no_write_drive: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(rd_n && ack_n) |=> o_host_data_bus_oe_n) // R4
		else $error("bus driven outside read");
	a_tx_auto: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(auto_ff[0] && cts_n[0]) |=> !o_tx_enable[0]) // R5
		else $error("tx enabled with cts high");
	a_term_follow: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(!dma_ff[1] && dtr_ff[1]) |=> !o_term_ready_req_n_ch1) // R10
		else $error("terminal ready not following bit");
	a_cts_event: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(cts_ie_ff[0] && $changed(cts_n[0])) |=> pend_ff[0]) // R7
		else $error("cts edge lost");
	a_ack_vector: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		ack_rd |=> (o_host_data_bus == $past(vector_ff))) // R16
		else $error("vector not returned");
endmodule

/* File: test/scc_host_model.sv */
// host-side data bus and upstream chain partner model
`timescale 1ns/1ps
module scc_host_model
(
	input wire logic i_ref_clk,
	input wire logic i_host_drv,
	input wire logic [7:0] i_host_val,
	input wire logic i_dev_oe_n,
	input wire logic [7:0] i_dev_data,
	input wire logic i_upstream_busy,
	output logic [7:0] o_bus,
	output logic o_prio_in
);
	logic [7:0] float_ff = 8'h00;
	// remember the inverse of the last driven byte, shown while nobody drives
	always @(posedge i_ref_clk)
	begin
		if (!i_dev_oe_n || i_host_drv)
			float_ff <= ~o_bus;
	end
	// released bus never shows a stale byte
	assign o_bus = !i_dev_oe_n ? i_dev_data : i_host_drv ? i_host_val : float_ff;
	// upstream passes the chain only when idle
	assign o_prio_in = !i_upstream_busy;
endmodule

/* File: test/tb_dual_serial_ctrl_host_port.sv */
// testbench for the dual serial controller host port
`timescale 1ns/1ps
module tb_dual_serial_ctrl_host_port;
	import scc_port_pkg::*;
	logic clk = 0, rst = 1, ce_n = 1, cs = 0, dc = 0, rd_n = 1, wr_n = 1, ack_n = 1;
	logic cts0 = 1, cts1 = 1, dcd0 = 1, dcd1 = 1, busy = 0, drv = 0, prio_in;
	logic [1:0] dma = 0, stb, wstb, txe, rxe, rstb;
	logic [7:0] val = 0, bus, rdat, wdat, wd, dout;
	logic oe_n, chain, irq_oe_n, term0, term1;
	int failures = 0, total_checks = 0;
	always #5 clk = ~clk;
	dual_serial_ctrl_host_port u_dut (.i_ref_clk(clk), .i_rst(rst), .i_chip_en_n(ce_n),
		.i_chan_sel(cs), .i_data_cmd(dc), .i_rd_n(rd_n), .i_wr_n(wr_n),
		.i_host_data_bus(bus), .o_host_data_bus(dout), .o_host_data_bus_oe_n(oe_n),
		.i_irq_ack_n(ack_n), .i_prio_chain_in(prio_in), .o_prio_chain_out(chain),
		.o_irq_n_oe_n(irq_oe_n), .i_clear_to_send_n_ch0(cts0), .i_clear_to_send_n_ch1(cts1),
		.i_carrier_detect_n_ch0(dcd0), .i_carrier_detect_n_ch1(dcd1), .i_dma_req(dma),
		.i_rx_data_ch0(8'h3c), .i_rx_data_ch1(8'hc3), .o_tx_enable(txe), .o_rx_enable(rxe),
		.o_wr_data_stb(wstb), .o_wr_data(wd), .o_rd_data_stb(rstb),
		.o_term_ready_req_n_ch0(term0), .o_term_ready_req_n_ch1(term1));
	scc_host_model u_host (.i_ref_clk(clk), .i_host_drv(drv), .i_host_val(val),
		.i_dev_oe_n(oe_n), .i_dev_data(dout), .i_upstream_busy(busy), .o_bus(bus),
		.o_prio_in(prio_in));
	// ----------------
	// tasks
	// ----------------
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one bus access, strobe held 6 cycles, capture strobe and read data
	task automatic acc(input logic c, input logic d, input logic ch, input logic rd,
		input logic [7:0] v);
		ce_n = c;
		dc = d;
		cs = ch;
		rd_n = !rd;
		wr_n = rd;
		drv = !rd;
		val = v;
		stb = 0;
		rdat = 8'hxx;
		repeat (6)
		begin
			tick(1);
			if (|(wstb | rstb))
			begin
				stb = wstb | rstb;
				wdat = wd;
			end
			if (!oe_n)
				rdat = bus;
		end
		rd_n = 1;
		wr_n = 1;
		ce_n = 1;
		drv = 0;
		tick(4);
	endtask
	// ----------------
	// sequence
	// ----------------
	initial
	begin
		#100000;
		failures++;
		end_of_test();
	end
	initial
	begin
		tick(3);
		rst = 0;
		tick(3);
		chk("oe_n", oe_n, 1);
		chk("chain", chain, 1);
		acc(0, 0, 0, 0, 8'h03);
		chk("term0", term0, 0);
		chk("term1", term1, 1);
		acc(1, 0, 1, 0, 8'h03);
		chk("term1", term1, 1);
		acc(0, 1, 1, 0, 8'ha5);
		chk("stb", stb, 2'b10);
		chk("wdat", wdat, 8'ha5);
		chk("txe1", txe[1], 1);
		cts0 = 0;
		tick(5);
		acc(0, 0, 0, 1, 8'h00);
		chk("status", rdat & 8'h03, 8'h02);
		chk("stb", stb, 2'b00);
		chk("oe_n", oe_n, 1);
		acc(0, 1, 0, 1, 8'h00);
		chk("rdat", rdat, 8'h3c);
		chk("rstb", stb, 2'b01);
		acc(0, 0, 0, 0, 8'h07);
		chk("txe0", txe[0], 1);
		chk("rxe0", rxe[0], 0);
		cts0 = 1;
		dcd0 = 0;
		tick(5);
		chk("txe0", txe[0], 0);
		chk("rxe0", rxe[0], 1);
		acc(0, 0, 0, 0, 8'h4a);
		acc(0, 0, 0, 0, 8'h0f);
		cts0 = 0;
		tick(5);
		chk("irq", irq_oe_n, 0);
		chk("chain", chain, 0);
		ack_n = 0;
		tick(2);
		acc(1, 0, 0, 1, 8'h00);
		ack_n = 1;
		chk("vector", rdat, 8'h4a);
		chk("chain", chain, 0);
		acc(0, 0, 0, 0, 8'h8f);
		chk("irq", irq_oe_n, 1);
		chk("chain", chain, 1);
		busy = 1;
		tick(3);
		chk("chain", chain, 0);
		busy = 0;
		acc(0, 0, 1, 0, 8'h11);
		dcd1 = 0;
		tick(5);
		chk("irq", irq_oe_n, 0);
		acc(0, 0, 1, 0, 8'h91);
		chk("irq", irq_oe_n, 1);
		acc(0, 0, 1, 0, 8'h21);
		dma = 2'b10;
		tick(5);
		chk("term1", term1, 0);
		dma = 0;
		tick(5);
		chk("term1", term1, 1);
		end_of_test();
	end
endmodule
